// file: rtl/lcdrst_core.sv
// reset and initialisation logic of the lcd driver, with a plain register port
`timescale 1ns/1ps
// Operation
// - hardware reset low forces display off and normal polarity
// - hardware reset sets segment direction normal
// - hardware reset clears the serial shift register
// - hardware reset selects 1/9 bias
// - hardware reset cancels n-line reversal drive
// - any reset zeroes the n-line reversal count
// - hardware reset turns all-pixels-lit mode off
// - hardware reset stops oscillator, clears power save, zeroes power control
// - any reset turns static indicator off, register zero
// - any reset leaves read-modify-write mode
// - any reset sets start line to first line
// - any reset sets column address to zero
// - any reset sets page address to zero
// - any reset selects normal common scan direction
// - any reset zeroes the resistor ratio register
// - any reset leaves contrast set mode, contrast to 100000
// - soft reset touches only the second group of settings
// - drive voltage and boost nodes discharge while reset is low
// - status reset flag is one during any reset or initialisation
module lcdrst_core (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic hardware_reset_input_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic serial_bit,
   input wire logic serial_shift,
   output logic [7:0] reg_rdata,
   output lcdrst_pkg::lcdrst_hw_t hw_state,
   output lcdrst_pkg::lcdrst_sw_t sw_state,
   output logic discharge_lcd_drive_voltage,
   output logic discharge_boost_output_node,
   output logic resetting
);
   // ==================================================
   // reset conditions
   typedef enum logic [1:0] {LCDRST_RUN, LCDRST_SOFT} lcdrst_state_t;
   lcdrst_state_t state_q;
   logic hw_rst;
   logic wr_cmd;
   logic soft_go;
   logic [3:0] soft_cnt_q;
   logic sw_rst;
   logic cmd_on;
   logic cmd_off;
   logic cmd_psave;
   logic hit_cfg_a;
   logic hit_cfg_b;
   logic hit_addr;
   logic hit_shift;
   lcdrst_pkg::lcdrst_sw_t sw_init;
   logic display_on_q;
   logic display_inverse_q;
   logic seg_dir_rev_q;
   logic bias_1_7_q;
   logic nline_en_q;
   logic all_on_q;
   logic osc_run_q;
   logic power_save_q;
   logic [2:0] pwr_ctrl_q;
   logic [1:0] static_ind_q;
   logic rmw_q;
   logic com_rev_q;
   logic contrast_mode_q;
   logic [2:0] res_ratio_q;
   logic [5:0] contrast_q;
   logic [3:0] nline_cnt_q;
   logic [5:0] start_line_q;
   logic [7:0] column_q;
   logic [3:0] page_q;
   logic [7:0] shift_q;
   logic [7:0] rdata_d;

   // one address decoder for every write target
   function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] target);
      return wr && (addr == target);
   endfunction

   // pin is sampled synchronously; items hold for as long as it reads low
   assign hw_rst = !rstn || !hardware_reset_input_n;
   assign sw_rst = hw_rst || soft_go;
   assign wr_cmd = wr_hit(reg_wr, reg_addr, lcdrst_pkg::ADDR_CMD);
   assign soft_go = wr_cmd && (reg_wdata == lcdrst_pkg::CMD_SOFT_RESET);
   assign cmd_on = wr_cmd && (reg_wdata == lcdrst_pkg::CMD_DISP_ON);
   assign cmd_off = wr_cmd && (reg_wdata == lcdrst_pkg::CMD_DISP_OFF);
   assign cmd_psave = wr_cmd && (reg_wdata == lcdrst_pkg::CMD_POWER_SAVE);
   assign hit_cfg_a = wr_hit(reg_wr, reg_addr, lcdrst_pkg::ADDR_CFG_A);
   assign hit_cfg_b = wr_hit(reg_wr, reg_addr, lcdrst_pkg::ADDR_CFG_B);
   assign hit_addr = wr_hit(reg_wr, reg_addr, lcdrst_pkg::ADDR_ADDR);
   assign hit_shift = wr_hit(reg_wr, reg_addr, lcdrst_pkg::ADDR_SHIFT);
   assign sw_init = sw_reset_val();

   function automatic lcdrst_pkg::lcdrst_sw_t sw_reset_val();
      lcdrst_pkg::lcdrst_sw_t v;
      v.static_ind = lcdrst_pkg::STATIC_IND_RST;
      v.rmw = 1'b0;
      v.start_line = lcdrst_pkg::START_LINE_RST;
      v.column = lcdrst_pkg::COLUMN_RST;
      v.page = lcdrst_pkg::PAGE_RST;
      v.com_rev = 1'b0;
      v.res_ratio = lcdrst_pkg::RES_RATIO_RST;
      v.contrast_mode = 1'b0;
      v.contrast = lcdrst_pkg::CONTRAST_RST;
      v.nline_cnt = lcdrst_pkg::NLINE_CNT_RST;
      return v;
   endfunction

   // ==================================================
   // soft initialisation sequencer
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         state_q <= LCDRST_RUN;
         soft_cnt_q <= 4'h0;
      end else begin
         case (state_q)
            LCDRST_RUN: begin
               if (soft_go) begin
                  state_q <= LCDRST_SOFT;
                  soft_cnt_q <= lcdrst_pkg::SOFT_INIT_CYC;
               end
            end
            LCDRST_SOFT: begin
               if (soft_cnt_q <= 4'h1) begin
                  state_q <= LCDRST_RUN;
                  soft_cnt_q <= 4'h0;
               end else begin
                  soft_cnt_q <= soft_cnt_q - 4'h1;
               end
            end
            default: begin
               state_q <= LCDRST_RUN;
               soft_cnt_q <= 4'h0;
            end
         endcase
      end
   end

   // ==================================================
   // hardware-only settings; soft reset never reaches them
   // display on/off
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         display_on_q <= 1'b0;
      end else if (cmd_on) begin
         display_on_q <= 1'b1;
      end else if (cmd_off) begin
         display_on_q <= 1'b0;
      end
   end

   // display polarity
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         display_inverse_q <= 1'b0;
      end else if (hit_cfg_a) begin
         display_inverse_q <= reg_wdata[0];
      end
   end

   // segment direction
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         seg_dir_rev_q <= 1'b0;
      end else if (hit_cfg_a) begin
         seg_dir_rev_q <= reg_wdata[1];
      end
   end

   // bias select
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         bias_1_7_q <= 1'b0;
      end else if (hit_cfg_a) begin
         bias_1_7_q <= reg_wdata[2];
      end
   end

   // n-line reversal enable
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         nline_en_q <= 1'b0;
      end else if (hit_cfg_a) begin
         nline_en_q <= reg_wdata[3];
      end
   end

   // all pixels lit
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         all_on_q <= 1'b0;
      end else if (hit_cfg_a) begin
         all_on_q <= reg_wdata[4];
      end
   end

   // oscillator runs once the host has configured drive
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         osc_run_q <= 1'b0;
      end else if (hit_cfg_a) begin
         osc_run_q <= 1'b1;
      end
   end

   // power save, left only through hardware reset
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         power_save_q <= 1'b0;
      end else if (cmd_psave) begin
         power_save_q <= 1'b1;
      end
   end

   // power control
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         pwr_ctrl_q <= lcdrst_pkg::PWR_CTRL_RST;
      end else if (hit_cfg_a) begin
         pwr_ctrl_q <= reg_wdata[7:5];
      end
   end

   assign hw_state = {display_on_q, display_inverse_q, seg_dir_rev_q, bias_1_7_q, nline_en_q, all_on_q,
                      osc_run_q, power_save_q, pwr_ctrl_q};

   // ==================================================
   // settings shared by both resets
   // static indicator
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         static_ind_q <= sw_init.static_ind;
      end else if (hit_cfg_b) begin
         static_ind_q <= reg_wdata[1:0];
      end
   end

   // read-modify-write
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         rmw_q <= sw_init.rmw;
      end else if (hit_cfg_b) begin
         rmw_q <= reg_wdata[2];
      end
   end

   // common scan direction
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         com_rev_q <= sw_init.com_rev;
      end else if (hit_cfg_b) begin
         com_rev_q <= reg_wdata[3];
      end
   end

   // resistor ratio
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         res_ratio_q <= sw_init.res_ratio;
      end else if (hit_cfg_b) begin
         res_ratio_q <= reg_wdata[6:4];
      end
   end

   // contrast set mode
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         contrast_mode_q <= sw_init.contrast_mode;
      end else if (hit_cfg_b) begin
         contrast_mode_q <= reg_wdata[7];
      end
   end

   // contrast, no write path in this block
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         contrast_q <= sw_init.contrast;
      end
   end

   // n-line reversal count
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         nline_cnt_q <= sw_init.nline_cnt;
      end else if (hit_shift) begin
         nline_cnt_q <= reg_wdata[7:4];
      end
   end

   // start line, no write path in this block
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         start_line_q <= sw_init.start_line;
      end
   end

   // column address
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         column_q <= sw_init.column;
      end else if (hit_addr) begin
         column_q <= reg_wdata;
      end
   end

   // page address
   always_ff @(posedge core_clk) begin
      if (sw_rst) begin
         page_q <= sw_init.page;
      end else if (hit_shift) begin
         page_q <= reg_wdata[3:0];
      end
   end

   assign sw_state = {static_ind_q, rmw_q, com_rev_q, contrast_mode_q, res_ratio_q, contrast_q, nline_cnt_q,
                      start_line_q, column_q, page_q};

   // ==================================================
   // serial shift register, cleared by hardware reset only
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         shift_q <= lcdrst_pkg::SHIFT_RST;
      end else if (serial_shift) begin
         shift_q <= {shift_q[6:0], serial_bit};
      end
   end

   // ==================================================
   // discharge and status
   always_ff @(posedge core_clk) begin
      discharge_lcd_drive_voltage <= hw_rst;
      discharge_boost_output_node <= hw_rst;
   end

   always_ff @(posedge core_clk) begin
      // a soft reset write is flagged from the following cycle on
      resetting <= hw_rst || soft_go || (state_q == LCDRST_SOFT && soft_cnt_q > 4'h1);
   end

   always_comb begin
      rdata_d = 8'h00;
      case (reg_addr)
         lcdrst_pkg::ADDR_STATUS: begin
            rdata_d[lcdrst_pkg::ST_BUSY_BIT] = resetting;
            rdata_d[lcdrst_pkg::ST_DIR_BIT] = !hw_state.seg_dir_rev;
            rdata_d[lcdrst_pkg::ST_ONOFF_BIT] = !hw_state.display_on;
            rdata_d[lcdrst_pkg::ST_RESET_BIT] = resetting;
         end
         lcdrst_pkg::ADDR_CFG_A: rdata_d = {hw_state.pwr_ctrl, hw_state.all_on, hw_state.nline_en,
                                            hw_state.bias_1_7, hw_state.seg_dir_rev, hw_state.display_inverse};
         lcdrst_pkg::ADDR_CFG_B: rdata_d = {sw_state.contrast_mode, sw_state.res_ratio, sw_state.com_rev,
                                            sw_state.rmw, sw_state.static_ind};
         lcdrst_pkg::ADDR_ADDR: rdata_d = sw_state.column;
         lcdrst_pkg::ADDR_SHIFT: rdata_d = shift_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// file: pkg/lcdrst_pkg.sv
// package: constants and carrier types for the lcd driver reset and initialisation block
package lcdrst_pkg;
   // ==================================================
   // register offsets
   localparam logic [3:0] ADDR_CMD = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_CFG_A = 4'h2;
   localparam logic [3:0] ADDR_CFG_B = 4'h3;
   localparam logic [3:0] ADDR_ADDR = 4'h4;
   localparam logic [3:0] ADDR_SHIFT = 4'h5;
   // ==================================================
   // command codes written to the command register
   localparam logic [7:0] CMD_DISP_ON = 8'haf;
   localparam logic [7:0] CMD_DISP_OFF = 8'hae;
   localparam logic [7:0] CMD_SOFT_RESET = 8'he2;
   localparam logic [7:0] CMD_POWER_SAVE = 8'h01;
   // ==================================================
   // reset values
   localparam logic [2:0] PWR_CTRL_RST = 3'h0;
   localparam logic [1:0] STATIC_IND_RST = 2'h0;
   localparam logic [2:0] RES_RATIO_RST = 3'h0;
   localparam logic [5:0] CONTRAST_RST = 6'h20;
   localparam logic [3:0] NLINE_CNT_RST = 4'h0;
   localparam logic [5:0] START_LINE_RST = 6'h00;
   localparam logic [7:0] COLUMN_RST = 8'h00;
   localparam logic [3:0] PAGE_RST = 4'h0;
   localparam logic [7:0] SHIFT_RST = 8'h00;
   // soft reset initialisation busy time
   localparam int SOFT_INIT_NS = 40;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [3:0] SOFT_INIT_CYC = 4'((SOFT_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // status byte field positions
   localparam int ST_RESET_BIT = 4;
   localparam int ST_ONOFF_BIT = 5;
   localparam int ST_DIR_BIT = 6;
   localparam int ST_BUSY_BIT = 7;
   // ==================================================
   typedef struct packed {
      logic display_on;
      logic display_inverse;
      logic seg_dir_rev;
      logic bias_1_7;
      logic nline_en;
      logic all_on;
      logic osc_run;
      logic power_save;
      logic [2:0] pwr_ctrl;
   } lcdrst_hw_t;
   typedef struct packed {
      logic [1:0] static_ind;
      logic rmw;
      logic com_rev;
      logic contrast_mode;
      logic [2:0] res_ratio;
      logic [5:0] contrast;
      logic [3:0] nline_cnt;
      logic [5:0] start_line;
      logic [7:0] column;
      logic [3:0] page;
   } lcdrst_sw_t;
endpackage

// file: test/lcdrst_core_chk.sv
// checker: port assertions for the lcd reset and initialisation block
`timescale 1ns/1ps
module lcdrst_core_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic hardware_reset_input_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire lcdrst_pkg::lcdrst_hw_t hw_state,
   input wire lcdrst_pkg::lcdrst_sw_t sw_state,
   input wire logic discharge_lcd_drive_voltage,
   input wire logic discharge_boost_output_node,
   input wire logic resetting
);
   // ==========
   // sequences
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic [35:0] sw_rst;
   assign sw_rst = {8'h00, lcdrst_pkg::CONTRAST_RST, 22'h0};
   sequence s_soft_cmd;
      reg_wr && reg_addr == lcdrst_pkg::ADDR_CMD && reg_wdata == lcdrst_pkg::CMD_SOFT_RESET && hardware_reset_input_n;
   endsequence
   // four cycles of busy, then free again
   sequence s_init_busy;
      resetting [*4] ##1 !resetting;
   endsequence
   a_pin_clears_hw: assert property (!hardware_reset_input_n |=> hw_state == '0)
      else $error("hw settings not cleared by reset pin");
   a_pin_resets_sw: assert property (!hardware_reset_input_n |=> sw_state == sw_rst)
      else $error("sw settings not reset by reset pin");
   a_pin_discharge: assert property (!hardware_reset_input_n |=> discharge_lcd_drive_voltage && discharge_boost_output_node)
      else $error("no discharge during reset");
   a_pin_flag: assert property (!hardware_reset_input_n |=> resetting)
      else $error("reset flag low during reset");
   a_release_ends: assert property ($rose(hardware_reset_input_n) |=> !resetting && !discharge_lcd_drive_voltage)
      else $error("reset effects outlast release");
   a_soft_keeps_hw: assert property (s_soft_cmd |=> $stable(hw_state))
      else $error("soft reset touched hw settings");
   a_soft_clears_sw: assert property (s_soft_cmd |=> sw_state == sw_rst)
      else $error("soft reset missed sw settings");
   a_soft_busy: assert property (s_soft_cmd |=> s_init_busy)
      else $error("soft reset busy span wrong");
   a_status_read: assert property (reg_rd && reg_addr == lcdrst_pkg::ADDR_STATUS |=> reg_rdata ==
      {$past(resetting), !$past(hw_state.seg_dir_rev), !$past(hw_state.display_on), $past(resetting), 4'h0})
      else $error("status byte wrong");
endmodule
bind lcdrst_core lcdrst_core_chk u_lcdrst_core_chk (.core_clk(core_clk), .rstn(rstn),
   .hardware_reset_input_n(hardware_reset_input_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_state(hw_state), .sw_state(sw_state),
   .discharge_lcd_drive_voltage(discharge_lcd_drive_voltage),
   .discharge_boost_output_node(discharge_boost_output_node), .resetting(resetting));

// file: test/lcdrst_host.sv
// partner model: host side of the reset pin, serial port and external supply
`timescale 1ns/1ps
module lcdrst_host (
   input wire logic core_clk,
   output logic hardware_reset_input_n,
   output logic serial_bit,
   output logic serial_shift,
   output logic ext_supply_on
);
   // reset held from power-up, every line driven, never floating
   initial begin
      hardware_reset_input_n = 1'b0;
      serial_bit = 1'b0;
      serial_shift = 1'b0;
      ext_supply_on = 1'b0;
   end
   task automatic pin_reset(input int n);
      @(posedge core_clk);
      ext_supply_on <= 1'b0;
      hardware_reset_input_n <= 1'b0;
      repeat (n) @(posedge core_clk);
      hardware_reset_input_n <= 1'b1;
      @(posedge core_clk);
      ext_supply_on <= 1'b1;
   endtask
   task automatic shift_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge core_clk);
         serial_bit <= b[i];
         serial_shift <= 1'b1;
      end
      @(posedge core_clk);
      serial_shift <= 1'b0;
      // idle line shows no stale bit
      serial_bit <= ~b[0];
   endtask
   task automatic supply_off();
      @(posedge core_clk);
      ext_supply_on <= 1'b0;
   endtask
endmodule

// file: test/tb_lcdrst_core.sv
// testbench: register-port scenarios for the lcd reset and initialisation block
`timescale 1ns/1ps
module tb_lcdrst_core;
   logic core_clk;
   logic rstn;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic pin_n;
   logic serial_bit;
   logic serial_shift;
   logic ext_on;
   logic dis_v;
   logic dis_b;
   logic resetting;
   lcdrst_pkg::lcdrst_hw_t hw_state;
   lcdrst_pkg::lcdrst_sw_t sw_state;
   lcdrst_pkg::lcdrst_sw_t sw_rst;
   logic [7:0] q;
   int n_fail;
   int compares;
   lcdrst_core u_lcdrst_core (.core_clk(core_clk), .rstn(rstn), .hardware_reset_input_n(pin_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .serial_bit(serial_bit), .serial_shift(serial_shift),
      .reg_rdata(reg_rdata), .hw_state(hw_state), .sw_state(sw_state), .discharge_lcd_drive_voltage(dis_v),
      .discharge_boost_output_node(dis_b), .resetting(resetting));
   lcdrst_host u_lcdrst_host (.core_clk(core_clk), .hardware_reset_input_n(pin_n), .serial_bit(serial_bit),
      .serial_shift(serial_shift), .ext_supply_on(ext_on));
   // ==========
   // tasks
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: byte %h wanted %h", $time, got, exp);
      end
   endtask
   task automatic chk_st(input logic [35:0] got, input logic [35:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: state %h wanted %h", $time, got, exp);
      end
   endtask
   task automatic chk_hw(input logic [10:0] got, input logic [10:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: hw state %h wanted %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      n_fail++;
      $display("unexpected at %0t: run hung", $time);
      final_report;
   end
   initial begin
      n_fail = 0;
      compares = 0;
      rstn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sw_rst = '0;
      sw_rst.contrast = lcdrst_pkg::CONTRAST_RST;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      u_lcdrst_host.pin_reset(3);
      rd(lcdrst_pkg::ADDR_STATUS, q);
      chk8(q, 8'h60);
      chk_hw(hw_state, 11'h000);
      chk_st(sw_state, sw_rst);
      wr(lcdrst_pkg::ADDR_CFG_A, 8'hff);
      wr(lcdrst_pkg::ADDR_CMD, lcdrst_pkg::CMD_DISP_ON);
      wr(lcdrst_pkg::ADDR_CFG_B, 8'hff);
      wr(lcdrst_pkg::ADDR_ADDR, 8'h5a);
      wr(lcdrst_pkg::ADDR_SHIFT, 8'h9c);
      wr(4'hf, 8'hff);
      u_lcdrst_host.shift_byte(8'ha5);
      rd(lcdrst_pkg::ADDR_CFG_A, q);
      chk8(q, 8'hff);
      rd(lcdrst_pkg::ADDR_CFG_B, q);
      chk8(q, 8'hff);
      chk_st(sw_state, {8'hff, 6'h20, 4'h9, 6'h00, 8'h5a, 4'hc});
      rd(4'hf, q);
      chk8(q, 8'h00);
      rd(lcdrst_pkg::ADDR_STATUS, q);
      chk8(q, 8'h00);
      chk_hw(hw_state, 11'h7f7);
      // soft reset, status read while still initialising
      wr(lcdrst_pkg::ADDR_CMD, lcdrst_pkg::CMD_SOFT_RESET);
      rd(lcdrst_pkg::ADDR_STATUS, q);
      chk8(q, 8'h90);
      chk_hw(hw_state, 11'h7f7);
      chk_st(sw_state, sw_rst);
      rd(lcdrst_pkg::ADDR_SHIFT, q);
      chk8(q, 8'ha5);
      rd(lcdrst_pkg::ADDR_ADDR, q);
      chk8(q, 8'h00);
      repeat (5) @(posedge core_clk);
      rd(lcdrst_pkg::ADDR_STATUS, q);
      chk8(q, 8'h00);
      wr(lcdrst_pkg::ADDR_CMD, lcdrst_pkg::CMD_POWER_SAVE);
      wr(lcdrst_pkg::ADDR_CMD, lcdrst_pkg::CMD_DISP_OFF);
      rd(lcdrst_pkg::ADDR_STATUS, q);
      chk8(q, 8'h20);
      chk_hw(hw_state, 11'h3ff);
      u_lcdrst_host.supply_off();
      fork
         u_lcdrst_host.pin_reset(4);
         begin
            repeat (3) @(posedge core_clk);
            #1 chk8({dis_v, dis_b, resetting, ext_on, 4'h0}, 8'he0);
            chk_hw(hw_state, 11'h000);
         end
      join
      rd(lcdrst_pkg::ADDR_SHIFT, q);
      chk8(q, 8'h00);
      chk_hw(hw_state, 11'h000);
      chk_st(sw_state, sw_rst);
      final_report;
   end
endmodule
